/* File: src/isr_regs.vh */
// Register indices, field positions, reset values and counts of the status bank
`ifndef ISR_REGS_VH
`define ISR_REGS_VH

// Register indices; byte address is four times the index
`define ISR_IDX_PART 10'h000
`define ISR_IDX_ERR 10'h002
`define ISR_IDX_STAT 10'h003
`define ISR_IDX_AUX_FIRST 10'h004
`define ISR_IDX_AUX_LAST 10'h00b
`define ISR_IDX_ACC_FIRST 10'h00c
`define ISR_IDX_ACC_LAST 10'h011
`define ISR_IDX_RATE_FIRST 10'h012
`define ISR_IDX_RATE_LAST 10'h017
`define ISR_IDX_AUX_BASE 10'h040
`define ISR_IDX_AUX_RD_PTR 10'h041
`define ISR_IDX_AUX_WR_PTR 10'h042
`define ISR_IDX_AUX_WDATA 10'h043

// Error register fields
`define ISR_ERR_FATAL_BIT 0
`define ISR_ERR_CODE_LSB 1
`define ISR_ERR_CODE_MSB 4
`define ISR_ERR_OVR_BIT 6
`define ISR_ERR_LINK_BIT 7

// Status register fields
`define ISR_STAT_BUSY_BIT 2
`define ISR_STAT_IDLE_BIT 4
`define ISR_STAT_AUX_BIT 5
`define ISR_STAT_RATE_BIT 6
`define ISR_STAT_ACC_BIT 7

// Reset values
`define ISR_ERR_RST 8'h00
`define ISR_STAT_RST 8'h10
`define ISR_DATA_RST 8'h00
`define ISR_AUX_BASE_RST 8'h00
`define ISR_CODE_RST 4'h0

// Auxiliary burst shape and data byte counts
`define ISR_AUX_BURST_LEN 4'h8
`define ISR_AUX_WRITE_LEN 4'h1
`define ISR_AUX_BYTES 8
`define ISR_CORE_BYTES 12

`endif

/* File: src/isr_flag.v */
// Sticky event flag where a set wins over a clear in the same cycle
`default_nettype none

module isr_flag #(
  parameter [0:0] RST_VAL = 1'b0
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Event and clear
  input wire set,
  input wire clr,
  output reg q
);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST_VAL;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: src/isr_aux_seq.v */
// Auxiliary-link transfer sequencer: starts reads and writes, tracks busy
`default_nettype none
`include "isr_regs.vh"

module isr_aux_seq (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Start requests
  input wire start_rd,
  input wire start_wr,
  input wire fc_start,
  input wire [7:0] rd_addr,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [7:0] base,
  // Link master answers
  input wire link_done,
  input wire link_err,
  input wire link_rd_valid,
  input wire [7:0] link_rd_data,
  // Link master requests
  output reg link_req,
  output reg link_req_write,
  output reg [7:0] link_req_addr,
  output reg [7:0] link_req_wdata,
  output reg [3:0] link_req_len,
  // Towards the bank
  output reg busy,
  output reg cap_we,
  output reg [2:0] cap_idx,
  output reg [7:0] cap_data,
  output reg burst_done
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0] state;
  reg is_read;
  reg [2:0] cnt;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      is_read <= 1'b0;
      cnt <= 3'h0;
      link_req <= 1'b0;
      link_req_write <= 1'b0;
      link_req_addr <= 8'h00;
      link_req_wdata <= 8'h00;
      link_req_len <= 4'h0;
      busy <= 1'b0;
      cap_we <= 1'b0;
      cap_idx <= 3'h0;
      cap_data <= 8'h00;
      burst_done <= 1'b0;
    end else begin
      link_req <= 1'b0;
      cap_we <= 1'b0;
      burst_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          cnt <= 3'h0;
          if (start_wr) begin
            link_req <= 1'b1;
            link_req_write <= 1'b1;
            link_req_addr <= wr_addr;
            link_req_wdata <= wr_data;
            link_req_len <= `ISR_AUX_WRITE_LEN;
            is_read <= 1'b0;
            busy <= 1'b1;
            state <= ST_RUN;
          end else if (start_rd || fc_start) begin
            link_req <= 1'b1;
            link_req_write <= 1'b0;
            link_req_addr <= start_rd ? rd_addr : base;
            link_req_len <= `ISR_AUX_BURST_LEN;
            is_read <= 1'b1;
            busy <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          // byte n lands at slot n
          if (link_rd_valid && is_read) begin
            cap_we <= 1'b1;
            cap_idx <= cnt;
            cap_data <= link_rd_data;
            cnt <= cnt + 3'h1;
          end
          if (link_done || link_err) begin
            busy <= 1'b0;
            burst_done <= is_read & ~link_err;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: src/isr_bank.v */
// Status, error and auxiliary data register bank behind an AHB-Lite slave
// Operation
// - Register zero returns a fixed read-only identity byte; writes ignored.
// - Fatal fault bit 0 sets on boot/power failure; only resets clear it.
// - Error bits 4:1 show the internal fault code, read-only, reset zero.
// - Queue overrun bit 6 sets on streaming overfill; reading error clears it.
// - Link fault bit 7 sets on aux master error; reading error clears it.
// - Status bit 2 is high while an auxiliary transfer is in progress.
// - Status bit 4 low while a command runs; status resets to 0x10.
// - Status bit 5 sets on new aux data; any aux data read clears it.
// - Status bit 6 sets on new rate data; any rate data read clears it.
// - Status bit 7 sets on new accel data; any accel read clears it.
// - Aux registers 0x04-0x08 copy external registers base+0 to base+4.
// - Index 0x05 holds aux X upper byte from base+1, little-endian.
// - Aux registers 0x09-0x0B copy external registers base+5 to base+7.
`default_nettype none
`include "isr_regs.vh"

module isr_bank #(
  // Arbitrary identity value, not tied to any real part
  parameter [7:0] PART_ID = 8'h5a
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Core events and state
  input wire soft_reset,
  input wire fatal_fault,
  input wire [3:0] internal_fault_code,
  input wire queue_overrun,
  input wire command_busy,
  input wire feature_controller_start,
  // Core sample streams
  input wire accel_new,
  input wire [47:0] accel_sample,
  input wire rate_new,
  input wire [47:0] rate_sample,
  // Auxiliary link master
  input wire aux_link_done,
  input wire aux_link_err,
  input wire aux_link_rd_valid,
  input wire [7:0] aux_link_rd_data,
  output wire aux_link_req,
  output wire aux_link_req_write,
  output wire [7:0] aux_link_req_addr,
  output wire [7:0] aux_link_req_wdata,
  output wire [3:0] aux_link_req_len
);

  // Bank index range test shared by the clear-on-read decodes
  function in_range;
    input [9:0] idx;
    input [9:0] lo;
    input [9:0] hi;
    begin
      in_range = (idx >= lo) && (idx <= hi);
    end
  endfunction

  // Bus decode
  wire [9:0] a_idx;
  wire accept;
  wire rd_accept;
  reg wr_pend;
  reg [9:0] wr_idx;

  // Flags
  wire fatal_q;
  wire ovr_q;
  wire link_q;
  wire aux_rdy_q;
  wire rate_rdy_q;
  wire acc_rdy_q;
  wire rd_err;
  wire rd_aux;
  wire rd_acc;
  wire rd_rate;

  // State shown in the bank
  reg [3:0] code_q;
  reg cmd_idle_q;
  reg [7:0] aux_base;
  reg [7:0] aux_rd_ptr;
  reg [7:0] aux_wr_ptr;
  reg [7:0] aux_wdata;
  reg [7:0] aux_bytes [0:`ISR_AUX_BYTES-1];
  reg [7:0] core_bytes [0:`ISR_CORE_BYTES-1];
  reg start_rd;
  reg start_wr;

  // Sequencer taps
  wire aux_busy;
  wire cap_we;
  wire [2:0] cap_idx;
  wire [7:0] cap_data;
  wire burst_done;

  // Read mux
  reg [7:0] err_val;
  reg [7:0] stat_val;
  reg [7:0] next_rdata;
  integer i;
  integer j;

  assign a_idx = haddr[11:2];
  // Only NONSEQ/SEQ with hready high start a transfer
  assign accept = hsel & hready & htrans[1];
  assign rd_accept = accept & ~hwrite;
  assign rd_err = rd_accept & (a_idx == `ISR_IDX_ERR);
  assign rd_aux = rd_accept & in_range(a_idx, `ISR_IDX_AUX_FIRST, `ISR_IDX_AUX_LAST);
  assign rd_acc = rd_accept & in_range(a_idx, `ISR_IDX_ACC_FIRST, `ISR_IDX_ACC_LAST);
  assign rd_rate = rd_accept & in_range(a_idx, `ISR_IDX_RATE_FIRST, `ISR_IDX_RATE_LAST);

  isr_flag u_fatal (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(fatal_fault),
    .clr(soft_reset),
    .q(fatal_q)
  );

  isr_flag u_ovr (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(queue_overrun),
    .clr(rd_err | soft_reset),
    .q(ovr_q)
  );

  isr_flag u_link (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(aux_link_err),
    .clr(rd_err | soft_reset),
    .q(link_q)
  );

  isr_flag u_aux_rdy (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(burst_done),
    .clr(rd_aux | soft_reset),
    .q(aux_rdy_q)
  );

  isr_flag u_rate_rdy (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(rate_new),
    .clr(rd_rate | soft_reset),
    .q(rate_rdy_q)
  );

  isr_flag u_acc_rdy (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(accel_new),
    .clr(rd_acc | soft_reset),
    .q(acc_rdy_q)
  );

  // Core state tracked each cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q <= `ISR_CODE_RST;
      cmd_idle_q <= 1'b1;
    end else begin
      code_q <= soft_reset ? `ISR_CODE_RST : internal_fault_code;
      cmd_idle_q <= ~command_busy;
    end
  end

  // Core samples are latched so a read sees one coherent set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < `ISR_CORE_BYTES; i = i + 1) begin
        core_bytes[i] <= `ISR_DATA_RST;
      end
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        if (accel_new) begin
          core_bytes[i] <= accel_sample[i*8 +: 8];
        end
        if (rate_new) begin
          core_bytes[i+6] <= rate_sample[i*8 +: 8];
        end
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (j = 0; j < `ISR_AUX_BYTES; j = j + 1) begin
        aux_bytes[j] <= `ISR_DATA_RST;
      end
    end else if (cap_we) begin
      aux_bytes[cap_idx] <= cap_data;
    end
  end

  // Write data phase: only the aux control registers take host data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 10'h000;
      aux_base <= `ISR_AUX_BASE_RST;
      aux_rd_ptr <= `ISR_DATA_RST;
      aux_wr_ptr <= `ISR_DATA_RST;
      aux_wdata <= `ISR_DATA_RST;
      start_rd <= 1'b0;
      start_wr <= 1'b0;
    end else begin
      start_rd <= 1'b0;
      start_wr <= 1'b0;
      wr_pend <= accept & hwrite;
      if (accept) begin
        wr_idx <= a_idx;
      end
      if (wr_pend) begin
        case (wr_idx)
          `ISR_IDX_AUX_BASE: begin
            aux_base <= hwdata[7:0];
          end
          `ISR_IDX_AUX_WDATA: begin
            aux_wdata <= hwdata[7:0];
          end
          `ISR_IDX_AUX_RD_PTR: begin
            // Dropped while a transfer runs; the link cannot queue
            if (!aux_busy) begin
              aux_rd_ptr <= hwdata[7:0];
              start_rd <= 1'b1;
            end
          end
          `ISR_IDX_AUX_WR_PTR: begin
            if (!aux_busy) begin
              aux_wr_ptr <= hwdata[7:0];
              start_wr <= 1'b1;
            end
          end
          default: begin
            start_rd <= 1'b0;
          end
        endcase
      end
    end
  end

  isr_aux_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .start_rd(start_rd),
    .start_wr(start_wr),
    .fc_start(feature_controller_start),
    .rd_addr(aux_rd_ptr),
    .wr_addr(aux_wr_ptr),
    .wr_data(aux_wdata),
    .base(aux_base),
    .link_done(aux_link_done),
    .link_err(aux_link_err),
    .link_rd_valid(aux_link_rd_valid),
    .link_rd_data(aux_link_rd_data),
    .link_req(aux_link_req),
    .link_req_write(aux_link_req_write),
    .link_req_addr(aux_link_req_addr),
    .link_req_wdata(aux_link_req_wdata),
    .link_req_len(aux_link_req_len),
    .busy(aux_busy),
    .cap_we(cap_we),
    .cap_idx(cap_idx),
    .cap_data(cap_data),
    .burst_done(burst_done)
  );

  // Error and status words; reserved bits stay zero
  always @* begin
    err_val = `ISR_ERR_RST;
    err_val[`ISR_ERR_FATAL_BIT] = fatal_q;
    err_val[`ISR_ERR_CODE_MSB:`ISR_ERR_CODE_LSB] = code_q;
    err_val[`ISR_ERR_OVR_BIT] = ovr_q;
    err_val[`ISR_ERR_LINK_BIT] = link_q;
    stat_val = 8'h00;
    stat_val[`ISR_STAT_BUSY_BIT] = aux_busy;
    stat_val[`ISR_STAT_IDLE_BIT] = cmd_idle_q;
    stat_val[`ISR_STAT_AUX_BIT] = aux_rdy_q;
    stat_val[`ISR_STAT_RATE_BIT] = rate_rdy_q;
    stat_val[`ISR_STAT_ACC_BIT] = acc_rdy_q;
  end

  always @* begin
    next_rdata = 8'h00;
    if (in_range(a_idx, `ISR_IDX_AUX_FIRST, `ISR_IDX_AUX_LAST)) begin
      next_rdata = aux_bytes[a_idx[2:0] - 3'h4];
    end else if (in_range(a_idx, `ISR_IDX_ACC_FIRST, `ISR_IDX_RATE_LAST)) begin
      next_rdata = core_bytes[a_idx[3:0] - 4'hc];
    end else begin
      case (a_idx)
        `ISR_IDX_PART: begin
          next_rdata = PART_ID;
        end
        `ISR_IDX_ERR: begin
          next_rdata = err_val;
        end
        `ISR_IDX_STAT: begin
          next_rdata = stat_val;
        end
        `ISR_IDX_AUX_BASE: begin
          next_rdata = aux_base;
        end
        `ISR_IDX_AUX_RD_PTR: begin
          next_rdata = aux_rd_ptr;
        end
        `ISR_IDX_AUX_WR_PTR: begin
          next_rdata = aux_wr_ptr;
        end
        `ISR_IDX_AUX_WDATA: begin
          next_rdata = aux_wdata;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Zero wait states: read data is registered at the address-phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_accept) begin
        hrdata <= {24'h00_0000, next_rdata};
      end
    end
  end

endmodule

`default_nettype wire

/* File: sim/isr_bank_monitor.sv */
// Assertion checker on the bank's bus and auxiliary request ports
`default_nettype none
module isr_bank_monitor #(
  parameter [7:0] PART_ID = 8'h5a
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Core events
  input wire logic soft_reset,
  input wire logic fatal_fault,
  input wire logic queue_overrun,
  input wire logic command_busy,
  // Auxiliary link
  input wire logic aux_link_done,
  input wire logic aux_link_err,
  input wire logic aux_link_req,
  input wire logic aux_link_req_write,
  input wire logic [3:0] aux_link_req_len
);
  logic fatal_q;
  logic link_busy;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [9:0] idx);
    hsel && hready && htrans[1] && !hwrite && haddr[11:2] == idx;
  endsequence
  // Error events may take two stages to reach the register
  sequence quiet;
    !aux_link_err && !queue_overrun;
  endsequence
  // Mirror of the sticky fault bit; set wins over soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fatal_q <= 1'b0;
    else if (fatal_fault) fatal_q <= 1'b1;
    else if (soft_reset) fatal_q <= 1'b0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) link_busy <= 1'b0;
    else if (aux_link_req) link_busy <= 1'b1;
    else if (aux_link_done || aux_link_err) link_busy <= 1'b0;
  end
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered with error");
  a_identity_read: assert property (rd_at(10'h000) |=> hrdata == {24'h0, PART_ID})
    else $error("identity read wrong");
  a_error_reserved: assert property (rd_at(10'h002) |=> hrdata[31:8] == 24'h0 && !hrdata[5])
    else $error("error reserved bits set");
  a_status_reserved: assert property (rd_at(10'h003) |=>
    {hrdata[31:8], hrdata[3], hrdata[1:0]} == 27'h0)
    else $error("status reserved bits set");
  a_idle_follows_cmd: assert property (rd_at(10'h003) ##0 $stable(command_busy) |=>
    hrdata[4] == !$past(command_busy))
    else $error("idle bit does not follow command state");
  a_fatal_sticky: assert property (rd_at(10'h002) |=> hrdata[0] == $past(fatal_q))
    else $error("fatal bit wrong");
  a_flags_clear_read: assert property (quiet[*3] ##0 rd_at(10'h002) ##1
    quiet[*3] ##0 rd_at(10'h002) |=> hrdata[7:6] == 2'b00)
    else $error("read-clear flags survived a read");
  a_read_len_eight: assert property (aux_link_req && !aux_link_req_write |->
    aux_link_req_len == 4'h8)
    else $error("aux read burst not eight bytes");
  a_single_request: assert property (aux_link_req |-> !link_busy ##1 !aux_link_req)
    else $error("aux request overlaps a transfer");
endmodule
bind isr_bank isr_bank_monitor #(.PART_ID(PART_ID)) u_isr_bank_monitor (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .soft_reset(soft_reset), .fatal_fault(fatal_fault), .queue_overrun(queue_overrun),
  .command_busy(command_busy), .aux_link_done(aux_link_done), .aux_link_err(aux_link_err),
  .aux_link_req(aux_link_req), .aux_link_req_write(aux_link_req_write),
  .aux_link_req_len(aux_link_req_len));
`default_nettype wire

/* File: sim/isr_aux_model.sv */
// Behavioural auxiliary link master and external sensor
`default_nettype none
module isr_aux_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Requests
  input wire logic req,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [3:0] req_len,
  // Scenario knobs
  input wire logic [7:0] stall,
  input wire logic fail,
  // Answers
  output logic done,
  output logic err,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  logic [7:0] last_addr;
  logic [7:0] last_wdata;
  logic [3:0] last_len;
  logic last_write;
  logic bad;
  int n_req;
  initial begin
    {done, err, rd_valid, rd_data, n_req} = '0;
    forever begin
      @(negedge hclk);
      if (hresetn && req) begin
        n_req++;
        {last_write, last_addr, last_wdata, last_len, bad} = {req_write, req_addr, req_wdata,
          req_len, fail};
        repeat (stall + 1) @(posedge hclk);
        for (int i = 0; i < last_len && !bad && !last_write; i++) begin
          rd_valid <= 1'b1;
          rd_data <= (last_addr + i[7:0]) ^ 8'ha5;
          @(posedge hclk);
        end
        rd_valid <= 1'b0;
        {done, err} <= {!bad, bad};
        @(posedge hclk);
        {done, err} <= 2'b00;
      end
      // Idle data line keeps moving so stale bytes never pass
      rd_data <= ~rd_data;
    end
  end
endmodule
`default_nettype wire

/* File: sim/tb_isr_bank.sv */
// Self-checking bench for the status, error and auxiliary data bank
`default_nettype none
module tb_isr_bank;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [7:0] ID = 8'h3c;
  // Core event strobes raised by pulse
  localparam int EV_FATAL = 0, EV_OVR = 1, EV_SRST = 2, EV_ACC = 3, EV_RATE = 4, EV_FC = 5;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, soft_reset, fatal_fault;
  logic queue_overrun, command_busy, fc_start, accel_new, rate_new;
  logic done, err, rd_valid, req, req_write, fail;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic [3:0] code, req_len;
  logic [47:0] accel_sample, rate_sample;
  logic [7:0] rd_data, req_addr, req_wdata, stall;
  int n_errors, n_checks, cyc;
  isr_bank #(.PART_ID(ID)) u_isr_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .soft_reset(soft_reset), .fatal_fault(fatal_fault), .internal_fault_code(code),
    .queue_overrun(queue_overrun), .command_busy(command_busy),
    .feature_controller_start(fc_start), .accel_new(accel_new), .accel_sample(accel_sample),
    .rate_new(rate_new), .rate_sample(rate_sample), .aux_link_done(done),
    .aux_link_err(err), .aux_link_rd_valid(rd_valid), .aux_link_rd_data(rd_data),
    .aux_link_req(req), .aux_link_req_write(req_write), .aux_link_req_addr(req_addr),
    .aux_link_req_wdata(req_wdata), .aux_link_req_len(req_len));
  isr_aux_model u_isr_aux_model (.hclk(hclk), .hresetn(hresetn), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_len(req_len),
    .stall(stall), .fail(fail), .done(done), .err(err), .rd_valid(rd_valid),
    .rd_data(rd_data));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, idx, 2'b00, wr};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, 24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] g;
    xfer(idx, 1'b0, 8'h00, g);
    chk(nm, e, g);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] g;
    xfer(idx, 1'b1, d, g);
  endtask
  task automatic pulse(input int k);
    @(posedge hclk);
    fatal_fault <= (k == EV_FATAL);
    queue_overrun <= (k == EV_OVR);
    soft_reset <= (k == EV_SRST);
    accel_new <= (k == EV_ACC);
    rate_new <= (k == EV_RATE);
    fc_start <= (k == EV_FC);
    @(posedge hclk);
    {fatal_fault, queue_overrun, soft_reset, accel_new, rate_new, fc_start} <= '0;
  endtask
  // Wait for the k-th request, then until the busy bit drops
  task automatic wait_link(input int k);
    logic [31:0] g;
    while (u_isr_aux_model.n_req < k) @(posedge hclk);
    g = 32'h4;
    while (g[2] !== 1'b0) xfer(10'h003, 1'b0, 8'h00, g);
  endtask
  task automatic t_reset_values;
    rd_chk("identity", 10'h000, {24'h0, ID});
    wr(10'h000, 8'hff);
    rd_chk("identity after write", 10'h000, {24'h0, ID});
    rd_chk("error reset", 10'h002, 32'h0);
    rd_chk("status reset", 10'h003, 32'h10);
    wr(10'h004, 8'h77);
    rd_chk("aux byte after write", 10'h004, 32'h0);
    rd_chk("unmapped", 10'h030, 32'h0);
    $display("test reset_values done");
  endtask
  task automatic t_error_flags;
    @(posedge hclk);
    code <= 4'h9;
    pulse(EV_FATAL);
    pulse(EV_OVR);
    rd_chk("error set", 10'h002, 32'h53);
    rd_chk("error after read", 10'h002, 32'h13);
    rd_chk("error again", 10'h002, 32'h13);
    @(posedge hclk);
    code <= 4'h0;
    pulse(EV_SRST);
    rd_chk("error after soft reset", 10'h002, 32'h0);
    $display("test error_flags done");
  endtask
  task automatic t_status_flags;
    @(posedge hclk);
    command_busy <= 1'b1;
    pulse(EV_ACC);
    pulse(EV_RATE);
    rd_chk("status busy new data", 10'h003, 32'hc0);
    rd_chk("accel x high", 10'h00d, 32'h22);
    rd_chk("status accel read", 10'h003, 32'h40);
    rd_chk("rate z high", 10'h017, 32'hab);
    @(posedge hclk);
    command_busy <= 1'b0;
    rd_chk("status idle", 10'h003, 32'h10);
    $display("test status_flags done");
  endtask
  task automatic t_aux_burst;
    wr(10'h040, 8'h30);
    @(posedge hclk);
    stall <= 8'd20;
    pulse(EV_FC);
    rd_chk("status link busy", 10'h003, 32'h14);
    wait_link(1);
    rd_chk("status aux ready", 10'h003, 32'h30);
    for (int n = 0; n < 8; n++)
      rd_chk("aux byte", 10'h004 + n[9:0], {24'h0, (8'h30 + n[7:0]) ^ 8'ha5});
    rd_chk("status aux cleared", 10'h003, 32'h10);
    chk("link base address", 32'h30, {24'h0, u_isr_aux_model.last_addr});
    $display("test aux_burst done");
  endtask
  task automatic t_aux_fault_write;
    @(posedge hclk);
    {fail, stall} <= {1'b1, 8'd3};
    wr(10'h041, 8'h50);
    wait_link(2);
    chk("link read pointer", 32'h50, {24'h0, u_isr_aux_model.last_addr});
    rd_chk("error link fault", 10'h002, 32'h80);
    rd_chk("error link cleared", 10'h002, 32'h0);
    rd_chk("status no aux ready", 10'h003, 32'h10);
    rd_chk("aux byte kept", 10'h004, 32'h95);
    @(posedge hclk);
    fail <= 1'b0;
    wr(10'h043, 8'h5c);
    wr(10'h042, 8'h21);
    wait_link(3);
    chk("link write", 32'h0011215c, {11'h0, u_isr_aux_model.last_write,
      u_isr_aux_model.last_len, u_isr_aux_model.last_addr, u_isr_aux_model.last_wdata});
    $display("test aux_fault_write done");
  endtask
  initial begin
    {hsel, hwrite, soft_reset, fatal_fault, queue_overrun, command_busy} = '0;
    {fc_start, accel_new, rate_new, fail, htrans, haddr, hwdata, code} = '0;
    {n_errors, n_checks, hresetn} = '0;
    stall = 8'd2;
    accel_sample = 48'h665544332211;
    rate_sample = 48'hab0000000000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_error_flags();
    t_status_flags();
    t_aux_burst();
    t_aux_fault_write();
    tally_and_finish();
  end
endmodule
`default_nettype wire
